// ==== sbgsr_pkg.sv ====
// Constants and types for the baud generator and soft reset block
`default_nettype none
package sbgsr_pkg;
	// Register byte offsets
	localparam logic [11:0] ADDR_DIVIDER  = 12'h000;
	localparam logic [11:0] ADDR_FRACTION = 12'h004;
	localparam logic [11:0] ADDR_CHANNEL  = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00C;
	localparam int          ADDR_W        = 12;
	// Divider control fields
	localparam int DIV_N_LSB    = 0;
	localparam int CLK_SEL_LSB  = 4;
	localparam int FRAC_EN_BIT  = 6;
	localparam int DIV_RSVD_BIT = 7;
	localparam int FRAC_K_LSB   = 0;
	// Channel control fields
	localparam int KEY_LSB      = 0;
	localparam int RX_EN_BIT    = 2;
	localparam int TX_EN_BIT    = 3;
	localparam int UART_BIT     = 4;
	// Status flag positions
	localparam int FLG_TX_EMPTY = 0;
	localparam int FLG_RX_FULL  = 1;
	localparam int FLG_TX_RUN   = 2;
	localparam int FLG_OVERRUN  = 3;
	localparam int FLG_PARITY   = 4;
	localparam int FLG_FRAMING  = 5;
	localparam int FLG_W        = 6;
	// Reset values
	localparam logic [7:0]       DIVIDER_RST  = 8'h00;
	localparam logic [3:0]       FRACTION_RST = 4'h0;
	localparam logic [FLG_W-1:0] FLAGS_RST    = 6'h00;
	// Key codes
	localparam logic [1:0] KEY_ARM  = 2'h2;
	localparam logic [1:0] KEY_FIRE = 2'h1;
	// Clock select codes
	localparam logic [1:0] CLK_DIV1  = 2'h0;
	localparam logic [1:0] CLK_DIV4  = 2'h1;
	localparam logic [1:0] CLK_DIV16 = 2'h2;
	localparam logic [1:0] CLK_DIV64 = 2'h3;
	// Divider counts
	localparam logic [4:0] N_ZERO_CODE = 5'h10;
	localparam logic [4:0] FRAC_WHOLE  = 5'h10;
	localparam logic [5:0] TAP4_MASK   = 6'h03;
	localparam logic [5:0] TAP16_MASK  = 6'h0F;
	localparam logic [5:0] TAP64_MASK  = 6'h3F;

	typedef enum logic {
		KEY_IDLE  = 1'b0,
		KEY_ARMED = 1'b1
	} sbgsr_key_t;
endpackage
`default_nettype wire

// ==== sbgsr_baud_if.sv ====
// Configuration and tick bundle between register file and generator
`timescale 1ns/1ps
`default_nettype none
interface sbgsr_baud_if;
	logic [1:0] clkSel;
	logic [3:0] divN;
	logic       fracEn;
	logic [3:0] fracK;
	logic       baudTick;
	modport ctrl (output clkSel, output divN, output fracEn, output fracK, input baudTick);
	modport gen (input clkSel, input divN, input fracEn, input fracK, output baudTick);
endinterface
`default_nettype wire

// ==== sbgsr_baud_gen.sv ====
// Prescaler taps and N or N + (16-K)/16 divider
`timescale 1ns/1ps
`default_nettype none
module sbgsr_baud_gen (
	input  wire logic   mclk,
	input  wire logic   sys_rst,
	sbgsr_baud_if.gen   cfg
);
	typedef struct packed {
		logic [5:0] presc;
		logic [4:0] cnt;
		logic [3:0] acc;
		logic       tick;
	} sbgsr_gen_t;

	sbgsr_gen_t s_q;
	sbgsr_gen_t s_d;
	logic       tap;
	logic [4:0] nVal;
	logic [4:0] fracInc;
	logic [4:0] accSum;
	logic       stretch;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic tapPulse(input logic [5:0] p, input logic [1:0] sel);
		logic r;
		r = 1'b1;
		case (sel)
			sbgsr_pkg::CLK_DIV1:  r = 1'b1;
			sbgsr_pkg::CLK_DIV4:  r = ((p & sbgsr_pkg::TAP4_MASK) == sbgsr_pkg::TAP4_MASK);
			sbgsr_pkg::CLK_DIV16: r = ((p & sbgsr_pkg::TAP16_MASK) == sbgsr_pkg::TAP16_MASK);
			default:              r = (p == sbgsr_pkg::TAP64_MASK);
		endcase
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.presc = s_q.presc + 6'h01;
		tap = tapPulse(s_q.presc, cfg.clkSel);
		nVal = (cfg.divN == 4'h0) ? sbgsr_pkg::N_ZERO_CODE : {1'b0, cfg.divN};
		fracInc = sbgsr_pkg::FRAC_WHOLE - {1'b0, cfg.fracK};
		accSum = {1'b0, s_q.acc} + fracInc;
		// carry out marks a stretched period
		stretch = cfg.fracEn & accSum[4];
		if (tap) begin
			if (s_q.cnt == 5'h00) begin
				s_d.tick = 1'b1;
				s_d.acc = cfg.fracEn ? accSum[3:0] : 4'h0;
				// reload with N, or N+1 on a stretch
				s_d.cnt = nVal - 5'h01 + {4'h0, stretch};
			end else begin
				s_d.cnt = s_q.cnt - 5'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg.baudTick = s_q.tick;

	////////////////////////////////////////////////////////////////////////////////
	// Helper logic: taps seen per period and stretches per 16 periods
	logic [5:0] tapsSince;
	logic [5:0] expLen;
	logic [3:0] winCnt;
	logic [4:0] winStretch;
	logic       winClean;
	logic [3:0] winK;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tapsSince <= 6'h00;
			expLen <= 6'h00;
			winCnt <= 4'h0;
			winStretch <= 5'h00;
			winClean <= 1'b0;
			winK <= 4'h0;
		end else begin
			if (tap && s_q.cnt == 5'h00) begin
				tapsSince <= 6'h01;
				expLen <= {1'b0, s_d.cnt} + 6'h01;
				winCnt <= winCnt + 4'h1;
				if (winCnt == 4'hF) begin
					winStretch <= {4'h0, stretch};
					winClean <= cfg.fracEn;
					winK <= cfg.fracK;
				end else begin
					winStretch <= winStretch + {4'h0, stretch};
					winClean <= winClean & cfg.fracEn & (winK == cfg.fracK);
				end
			end else if (tap) begin
				tapsSince <= tapsSince + 6'h01;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_period_matches_reload: assert property (
		tap && s_q.cnt == 5'h00 && expLen != 6'h00 |-> tapsSince == expLen)
		else $error("baud period differs from reloaded length");
	a_plain_divide_n: assert property (
		tap && s_q.cnt == 5'h00 && !cfg.fracEn |=> s_q.cnt == $past(nVal) - 5'h01)
		else $error("plain divide reload is not N");
	a_frac_long_period: assert property (
		tap && s_q.cnt == 5'h00 && cfg.fracEn
			|=> s_q.cnt == $past(nVal) - 5'h01 || s_q.cnt == $past(nVal))
		else $error("fractional period not N or N+1");
	a_stretch_per_window: assert property (
		tap && s_q.cnt == 5'h00 && winCnt == 4'hF && winClean && cfg.fracEn && winK == cfg.fracK
			|-> winStretch == sbgsr_pkg::FRAC_WHOLE - {1'b0, winK})
		else $error("stretch count over 16 periods is not 16-K");
	a_tap_div64: assert property (
		cfg.clkSel == sbgsr_pkg::CLK_DIV64 && tap |-> s_q.presc == sbgsr_pkg::TAP64_MASK)
		else $error("divide-by-64 tap at wrong phase");
	a_tick_one_cycle: assert property (
		s_q.tick && cfg.clkSel != sbgsr_pkg::CLK_DIV1 |=> !s_q.tick)
		else $error("tick longer than one cycle on a slow tap");
	c_frac_tick: cover property (cfg.fracEn && s_q.tick);
	c_div64_tick: cover property (cfg.clkSel == sbgsr_pkg::CLK_DIV64 && s_q.tick);
endmodule
`default_nettype wire

// ==== sbgsr_top.sv ====
// APB registers, soft reset key and baud generator of one channel
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbgsr_top (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [5:0]  channelEvents,
	output logic             channelReset,
	output logic             rxEnable,
	output logic             txEnable,
	output logic             uartMode,
	output logic             baudTick
);
	typedef struct packed {
		logic [7:0]          divider;
		logic [3:0]          fracK;
		sbgsr_pkg::sbgsr_key_t key;
		logic                rxEn;
		logic                txEn;
		logic                uart;
		logic [5:0]          flags;
		logic                rstPulse;
		logic [31:0]         rdata;
	} sbgsr_regs_t;

	sbgsr_regs_t s_q;
	sbgsr_regs_t s_d;
	logic        wrEn;
	logic        wrLow;
	logic [1:0]  keyWr;
	sbgsr_baud_if baudBus ();

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic isMapped(input logic [11:0] a);
		return a == sbgsr_pkg::ADDR_DIVIDER || a == sbgsr_pkg::ADDR_FRACTION
			|| a == sbgsr_pkg::ADDR_CHANNEL || a == sbgsr_pkg::ADDR_STATUS;
	endfunction

	// Key field reads back as zero so a stale key cannot be replayed
	function automatic logic [31:0] regRead(input logic [11:0] a, input sbgsr_regs_t r);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			sbgsr_pkg::ADDR_DIVIDER:  v[7:0] = r.divider;
			sbgsr_pkg::ADDR_FRACTION: v[3:0] = r.fracK;
			sbgsr_pkg::ADDR_CHANNEL: begin
				v[sbgsr_pkg::RX_EN_BIT] = r.rxEn;
				v[sbgsr_pkg::TX_EN_BIT] = r.txEn;
				v[sbgsr_pkg::UART_BIT] = r.uart;
			end
			sbgsr_pkg::ADDR_STATUS:   v[5:0] = r.flags;
			default:                  v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);
	assign wrEn = psel & penable & pwrite & isMapped(paddr);
	assign wrLow = wrEn & pstrb[0];
	assign keyWr = pwdata[sbgsr_pkg::KEY_LSB +: 2];

	always_comb begin
		s_d = s_q;
		s_d.rstPulse = 1'b0;
		// Read data latched in setup so the bus sees a flop output
		if (psel && !penable) begin
			s_d.rdata = regRead(paddr, s_q);
		end
		if (wrLow) begin
			case (paddr)
				sbgsr_pkg::ADDR_DIVIDER:  s_d.divider = pwdata[7:0];
				sbgsr_pkg::ADDR_FRACTION: s_d.fracK = pwdata[3:0];
				sbgsr_pkg::ADDR_CHANNEL: begin
					s_d.rxEn = pwdata[sbgsr_pkg::RX_EN_BIT];
					s_d.txEn = pwdata[sbgsr_pkg::TX_EN_BIT];
					s_d.uart = pwdata[sbgsr_pkg::UART_BIT];
					// arm on 10, fire on 01 only when armed
					if (keyWr == sbgsr_pkg::KEY_ARM) begin
						s_d.key = sbgsr_pkg::KEY_ARMED;
					end else if (keyWr == sbgsr_pkg::KEY_FIRE && s_q.key == sbgsr_pkg::KEY_ARMED) begin
						s_d.key = sbgsr_pkg::KEY_IDLE;
						s_d.rstPulse = 1'b1;
					end else begin
						s_d.key = sbgsr_pkg::KEY_IDLE;
					end
				end
				sbgsr_pkg::ADDR_STATUS:   s_d.flags = s_q.flags & ~pwdata[5:0];
				default:                  s_d.key = s_q.key;
			endcase
		end
		// soft reset drops enables and flags
		if (s_d.rstPulse) begin
			s_d.rxEn = 1'b0;
			s_d.txEn = 1'b0;
			s_d.flags = sbgsr_pkg::FLAGS_RST;
		end
		// Late events win over any clear in the same cycle
		s_d.flags = s_d.flags | channelEvents;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{divider: sbgsr_pkg::DIVIDER_RST, fracK: sbgsr_pkg::FRACTION_RST,
				key: sbgsr_pkg::KEY_IDLE, flags: sbgsr_pkg::FLAGS_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// divider fields drive the generator
	assign baudBus.divN = s_q.divider[sbgsr_pkg::DIV_N_LSB +: 4];
	assign baudBus.clkSel = s_q.divider[sbgsr_pkg::CLK_SEL_LSB +: 2];
	assign baudBus.fracEn = s_q.divider[sbgsr_pkg::FRAC_EN_BIT];
	assign baudBus.fracK = s_q.fracK;

	sbgsr_baud_gen u_gen (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.cfg     (baudBus)
	);

	assign prdata = s_q.rdata;
	// one-cycle pulse restarts tx, rx and FIFO logic
	assign channelReset = s_q.rstPulse;
	assign rxEnable = s_q.rxEn;
	assign txEnable = s_q.txEn;
	assign uartMode = s_q.uart;
	assign baudTick = baudBus.baudTick;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_fire_needs_arm: assert property (
		s_q.rstPulse |-> $past(s_q.key) == sbgsr_pkg::KEY_ARMED
			&& $past(wrLow) && $past(paddr) == sbgsr_pkg::ADDR_CHANNEL
			&& $past(keyWr) == sbgsr_pkg::KEY_FIRE)
		else $error("soft reset without armed key");
	a_fire_unarmed_none: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_CHANNEL && keyWr == sbgsr_pkg::KEY_FIRE
			&& s_q.key == sbgsr_pkg::KEY_IDLE |=> !channelReset)
		else $error("soft reset fired without prior 10");
	a_reset_clears_enables: assert property (
		channelReset |-> !rxEnable && !txEnable && s_q.flags == $past(channelEvents))
		else $error("soft reset left enables or flags set");
	a_reset_single_pulse: assert property (
		channelReset |=> !channelReset)
		else $error("soft reset pulse longer than one cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Helper views of the write data for the checks below
	logic [7:0] wrLowByte;
	logic       wrUart;
	logic [5:0] clrMask;
	assign wrLowByte = pwdata[7:0];
	assign wrUart = pwdata[sbgsr_pkg::UART_BIT];
	assign clrMask = pwdata[sbgsr_pkg::FLG_W-1:0] & ~channelEvents;

	a_key_arms: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_CHANNEL && keyWr == sbgsr_pkg::KEY_ARM
			|=> s_q.key == sbgsr_pkg::KEY_ARMED)
		else $error("key 10 did not arm the soft reset");
	a_key_disarms: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_CHANNEL && keyWr != sbgsr_pkg::KEY_ARM
			|=> s_q.key == sbgsr_pkg::KEY_IDLE)
		else $error("channel write left the key armed");
	a_key_kept: assert property (
		!(wrLow && paddr == sbgsr_pkg::ADDR_CHANNEL) |=> s_q.key == $past(s_q.key))
		else $error("key state changed without a channel write");
	a_fire_keeps_mode: assert property (
		channelReset |-> uartMode == $past(wrUart))
		else $error("soft reset changed the written mode bit");
	a_event_sets_flag: assert property (
		channelEvents != 6'h00
			|=> (s_q.flags & $past(channelEvents)) == $past(channelEvents))
		else $error("channel event did not set its flag");
	// Ones written to status clear those flags
	a_flag_clear_ones: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_STATUS |=> (s_q.flags & $past(clrMask)) == 6'h00)
		else $error("status write did not clear flags");
	// Flags hold with no event, clear or reset
	a_flags_hold: assert property (
		!(wrLow && paddr == sbgsr_pkg::ADDR_STATUS) && !s_d.rstPulse && channelEvents == 6'h00
			|=> s_q.flags == $past(s_q.flags))
		else $error("flags changed without a cause");
	// Low byte strobe gates every write
	a_strobe_gates_write: assert property (
		psel && penable && pwrite && !pstrb[0]
			|=> s_q.divider == $past(s_q.divider) && s_q.fracK == $past(s_q.fracK)
			&& s_q.key == $past(s_q.key))
		else $error("write without low strobe changed a register");
	// Unmapped writes have no effect
	a_unmapped_no_write: assert property (
		psel && penable && pwrite && !isMapped(paddr)
			|=> s_q.divider == $past(s_q.divider) && s_q.fracK == $past(s_q.fracK)
			&& rxEnable == $past(rxEnable))
		else $error("unmapped write changed a register");
	// Read data stands through the access phase
	a_rdata_held: assert property (
		psel && penable |=> prdata == $past(prdata))
		else $error("read data moved after the access phase");
	// Unmapped reads return zero
	a_unmapped_reads_zero: assert property (
		psel && !penable && !isMapped(paddr) |=> prdata == 32'h0000_0000)
		else $error("unmapped read data not zero");
	a_divider_to_gen: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_DIVIDER
			|=> {baudBus.fracEn, baudBus.clkSel, baudBus.divN} == 7'($past(wrLowByte)))
		else $error("divider fields not passed to the generator");
	a_fraction_to_gen: assert property (
		wrLow && paddr == sbgsr_pkg::ADDR_FRACTION |=> baudBus.fracK == 4'($past(wrLowByte)))
		else $error("fraction not passed to the generator");
	c_soft_reset: cover property (channelReset);
	c_arm_then_fire: cover property (s_q.key == sbgsr_pkg::KEY_ARMED ##1 channelReset);
	c_unmapped: cover property (pslverr);
endmodule
`default_nettype wire

// ==== serial_baud_gen_soft_reset_tb.sv ====
// Self-checking bench for the baud generator and soft reset block
`timescale 1ns/1ps
`default_nettype none
module serial_baud_gen_soft_reset_tb;
	logic        mclk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  channelEvents;
	logic        channelReset;
	logic        rxEnable;
	logic        txEnable;
	logic        uartMode;
	logic        baudTick;
	int          nMismatch      = 0;
	int          samplesChecked = 0;
	int          cycles         = 0;
	int          nPulse         = 0;

	sbgsr_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .channelEvents(channelEvents),
		.channelReset(channelReset), .rxEnable(rxEnable), .txEnable(txEnable),
		.uartMode(uartMode), .baudTick(baudTick));

	always #2 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// Ceiling well above the slowest divide-by-64 measurement
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			nMismatch = nMismatch + 1;
			finish_test();
		end
	end

	// Counting high cycles also catches a pulse wider than one cycle
	always @(posedge mclk) begin
		if (channelReset === 1'b1) begin
			nPulse <= nPulse + 1;
		end
	end

	task automatic finish_test();
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		r = 32'h0;
		e = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) begin
				r = prdata;
				e = pslverr;
				break;
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk32(r, exp);
		chk1(e, expErr);
	endtask

	// Cycles spanned by n tick-to-tick periods, after aligning to a tick
	task automatic periods(input int n, output int total);
		int k;
		int c;
		total = 0;
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (baudTick !== 1'b1 && c < 2000);
		for (k = 0; k < n; k++) begin
			c = 0;
			do begin
				@(posedge mclk);
				c++;
			end while (baudTick !== 1'b1 && c < 2000);
			total += c;
		end
	endtask

	// New N loads at a period boundary but a new clock select at once, so a few periods are skipped
	task automatic baud(input logic [7:0] cfg, input int n, input int exp);
		int t;
		wr(sbgsr_pkg::ADDR_DIVIDER, {24'h0, cfg});
		periods(3, t);
		periods(n, t);
		chk32(32'(t), 32'(exp));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(sbgsr_pkg::ADDR_DIVIDER, 32'h0, 1'b0);
		rd(sbgsr_pkg::ADDR_FRACTION, 32'h0, 1'b0);
		wr(sbgsr_pkg::ADDR_FRACTION, 32'hFFFFFFFF);
		rd(sbgsr_pkg::ADDR_FRACTION, 32'h0000000F, 1'b0);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h10);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'hFFFFFFFF);
		rd(sbgsr_pkg::ADDR_DIVIDER, 32'h000000FF, 1'b0);
		pstrb <= 4'h0;
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h0);
		pstrb <= 4'hF;
		rd(sbgsr_pkg::ADDR_DIVIDER, 32'h000000FF, 1'b0);
		wr(12'h010, 32'hFFFFFFFF);
		rd(12'h010, 32'h0, 1'b1);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h0);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h0);
	endtask

	task automatic t_divide();
		int s;
		for (s = 0; s < 4; s++) begin
			baud({2'h0, 2'(s), 4'h2}, 4, 8 << (2 * s));
		end
		baud(8'h00, 4, 64);
		baud(8'h01, 4, 4);
		baud(8'h0F, 4, 60);
	endtask

	// Each 16 periods total tap * (16N + 16 - K); 32 periods fill a whole check window
	task automatic t_frac();
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h10);
		wr(sbgsr_pkg::ADDR_FRACTION, 32'h4);
		baud(8'h43, 32, 120);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h0F);
		wr(sbgsr_pkg::ADDR_FRACTION, 32'hF);
		baud(8'h4F, 32, 482);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h12);
		wr(sbgsr_pkg::ADDR_FRACTION, 32'h8);
		baud(8'h52, 32, 320);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h0);
	endtask

	task automatic t_reset();
		int p;
		@(posedge mclk);
		channelEvents <= 6'h3F;
		@(posedge mclk);
		channelEvents <= 6'h00;
		rd(sbgsr_pkg::ADDR_STATUS, 32'h3F, 1'b0);
		wr(sbgsr_pkg::ADDR_STATUS, 32'h01);
		rd(sbgsr_pkg::ADDR_STATUS, 32'h3E, 1'b0);
		p = nPulse;
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h05);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h06);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h04);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h05);
		repeat (3) @(posedge mclk);
		chk32(32'(nPulse - p), 32'h0);
		chk1(rxEnable, 1'b1);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h1E);
		wr(sbgsr_pkg::ADDR_DIVIDER, 32'h0);
		chk1(txEnable, 1'b1);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h1D);
		repeat (3) @(posedge mclk);
		chk32(32'(nPulse - p), 32'h1);
		chk1(rxEnable, 1'b0);
		chk1(txEnable, 1'b0);
		chk1(uartMode, 1'b1);
		rd(sbgsr_pkg::ADDR_STATUS, 32'h0, 1'b0);
		rd(sbgsr_pkg::ADDR_CHANNEL, 32'h10, 1'b0);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h0E);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h0D);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h0E);
		wr(sbgsr_pkg::ADDR_CHANNEL, 32'h0D);
		repeat (3) @(posedge mclk);
		chk32(32'(nPulse - p), 32'h3);
		chk1(txEnable, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk          = 1'b0;
		sys_rst       = 1'b1;
		psel          = 1'b0;
		penable       = 1'b0;
		pwrite        = 1'b0;
		paddr         = 12'h000;
		pwdata        = 32'h0;
		pstrb         = 4'hF;
		channelEvents = 6'h00;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_divide();
		t_frac();
		t_reset();
		finish_test();
	end
endmodule
`default_nettype wire
